// ==== core/scp_pkg.sv ====
// shared constants and types of the system clock select and prescaler
package scp_pkg;

    // register offsets on the plain register port
    localparam logic [3:0] ADDR_TRIM   = 4'h0;
    localparam logic [3:0] ADDR_DIVCTL = 4'h1;
    localparam logic [3:0] ADDR_ASYNC  = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;

    // divider control fields
    localparam int          DIVCTL_CE_BIT  = 7;
    localparam logic [7:0]  DIVCTL_UNLOCK  = 8'h80;
    localparam logic [3:0]  DIV_CODE_RESET = 4'h0;
    localparam logic [3:0]  DIV_CODE_DIV8  = 4'h3;
    localparam logic [3:0]  DIV_CODE_MAX   = 4'h8;
    localparam logic [2:0]  CE_WINDOW      = 3'h4;

    // async timer status fields
    localparam int ASYNC_TIMER_EXTERNAL_CLOCK_SELECT_BIT = 6;

    // status fields
    localparam int STAT_RC_BIT   = 0;
    localparam int STAT_EXT_BIT  = 1;
    localparam int STAT_RUN_BIT  = 2;
    localparam int STAT_TOSC_BIT = 3;

    // source select codes
    localparam logic [3:0] SRC_EXT = 4'h0;
    localparam logic [3:0] SRC_RC  = 4'h2;

    // start-up codes
    localparam logic [1:0] SUT_CK_ONLY = 2'h0;
    localparam logic [1:0] SUT_SHORT   = 2'h1;
    localparam logic [1:0] SUT_LONG    = 2'h2;

    // trim reset value before the calibration byte is caught
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // delays counted in source clock cycles
    localparam logic [13:0] RESET_CK_CYCLES = 14'h000E;
    localparam logic [13:0] WAKE_CK_CYCLES  = 14'h0006;

    // reset time-out runs on the watchdog oscillator ticks
    localparam int WDT_OSC_KHZ    = 128;
    localparam int T_RST_SHORT_US = 4100;
    localparam int T_RST_LONG_US  = 65000;
    localparam int RST_SHORT_TICKS = (T_RST_SHORT_US * WDT_OSC_KHZ + 999) / 1000;
    localparam int RST_LONG_TICKS  = (T_RST_LONG_US * WDT_OSC_KHZ + 999) / 1000;

    // static fuse configuration
    typedef struct packed {
        logic [3:0] source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       divide_by_eight_fuse;
        logic       clock_output_fuse;
    } scp_fuse_t;

    // sequencing states, one-hot
    typedef enum logic [4:0] {
        ST_LATCH = 5'h01,
        ST_CK    = 5'h02,
        ST_MS    = 5'h04,
        ST_RUN   = 5'h08,
        ST_WAKE  = 5'h10
    } scp_state_t;

endpackage

// ==== core/scp_delay.sv ====
// tick driven countdown delay with done pulse
module scp_delay (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // control
    input  wire logic        start,
    input  wire logic [13:0] load,
    input  wire logic        tick,
    // result
    output logic             busy,
    output logic             done
);

    typedef struct packed {
        logic [13:0] cnt;
        logic        busy;
        logic        done;
    } scp_dly_t;

    scp_dly_t s_r;
    scp_dly_t s_nxt;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (start)
        begin
            s_nxt.cnt  = load;
            s_nxt.busy = 1'b1;
        end
        else if (s_r.busy && (s_r.cnt == 14'h0000 || (tick && s_r.cnt == 14'h0001)))
        begin
            s_nxt.cnt  = 14'h0000;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
        end
        else if (s_r.busy && tick)
        begin
            s_nxt.cnt = s_r.cnt - 14'h0001;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign busy = s_r.busy;
    assign done = s_r.done;

endmodule

// ==== core/scp_divider.sv ====
// glitch-free power of two clock divider working on source ticks
module scp_divider (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // source and setting
    input  wire logic       tick_in,
    input  wire logic [3:0] code,
    // divided clock
    output logic            tick_out,
    output logic            level
);

    typedef struct packed {
        logic [7:0] cnt;
        logic [3:0] cur;
        logic       tick;
        logic       level;
    } scp_div_t;

    scp_div_t   s_r;
    scp_div_t   s_nxt;
    logic [8:0] factor;
    logic       last;

    // reserved codes saturate at the largest factor
    assign factor = (s_r.cur > scp_pkg::DIV_CODE_MAX) ? 9'h100 : (9'h001 << s_r.cur);
    assign last   = ({1'b0, s_r.cnt} == factor - 9'h001);

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (tick_in)
        begin
            if (last)
            begin
                // a new setting is taken only at the end of a whole old period
                s_nxt.cnt  = 8'h00;
                s_nxt.cur  = code;
                s_nxt.tick = 1'b1;
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
            // divide by one can only be shown as a half rate level
            if (factor == 9'h001)
                s_nxt.level = ~s_r.level;
            else
                s_nxt.level = ({1'b0, s_nxt.cnt} < (factor >> 1));
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign tick_out = s_r.tick;
    assign level    = s_r.level;

endmodule

// ==== core/scp_top.sv ====
// system clock source select, start-up delays, trim and prescaler control
//
// Added by the designer: the plain strobed port and the register addresses.
module scp_top #(
    parameter int RST_SHORT_TICKS = scp_pkg::RST_SHORT_TICKS,
    parameter int RST_LONG_TICKS  = scp_pkg::RST_LONG_TICKS
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RSTN,
    // register port
    input  wire logic [3:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [7:0]        RDATA,
    // static configuration
    input  wire scp_pkg::scp_fuse_t FUSE,
    input  wire logic [7:0]        CAL_BYTE,
    // pins and oscillators
    input  wire logic              MAIN_CLOCK_INPUT_PIN,
    input  wire logic              TIMER_OSC_PIN_ONE,
    input  wire logic              WDT_OSC_TICK,
    // wake from deep sleep
    input  wire logic              WAKE_REQ,
    output logic                   WAKE_DONE,
    // reset and clocks to the chip
    output logic                   CORE_RESET_N,
    output logic                   SYS_TICK,
    output logic                   ASY_TICK,
    // clock output pin
    output logic                   CLOCK_OUTPUT_PIN_O,
    output logic                   CLOCK_OUTPUT_PIN_OE_N,
    // oscillator control
    output logic      [7:0]        RC_OSCILLATOR_TRIM,
    output logic                   TOSC_ENABLE,
    output logic                   TOSC_EXT_CLOCK
);

    typedef struct packed {
        scp_pkg::scp_state_t st;
        scp_pkg::scp_fuse_t  fuse;
        logic                rc_sel;
        logic                ext_sel;
        logic [7:0]          trim;
        logic [3:0]          div_sel;
        logic                ce;
        logic [2:0]          ce_cnt;
        logic                ext_tclk;
        logic                xtal_prev;
        logic                tosc_prev;
        logic                asy_tick;
        logic                wake_done;
        logic [7:0]          rdata;
    } scp_top_t;

    scp_top_t    s_r;
    scp_top_t    s_nxt;

    logic        src_tick;
    logic        ck_start;
    logic [13:0] ck_load;
    logic        ck_done;
    logic        ms_start;
    logic [13:0] ms_load;
    logic        ms_done;
    logic        div_tick;
    logic        div_level;
    logic        wr_trim;
    logic        wr_div;
    logic        wr_async;
    logic        running;
    logic        tosc_ok;

    localparam logic [13:0] SHORT_LOAD = 14'(RST_SHORT_TICKS);
    localparam logic [13:0] LONG_LOAD  = 14'(RST_LONG_TICKS);

    // source clock: internal RC runs at the core rate, external is edge sampled
    always_comb
    begin
        if (s_r.ext_sel)
            src_tick = MAIN_CLOCK_INPUT_PIN && !s_r.xtal_prev;
        else if (s_r.rc_sel)
            src_tick = 1'b1;
        else
            src_tick = 1'b0;
    end

    assign wr_trim  = WR && (ADDR == scp_pkg::ADDR_TRIM);
    assign wr_div   = WR && (ADDR == scp_pkg::ADDR_DIVCTL);
    assign wr_async = WR && (ADDR == scp_pkg::ADDR_ASYNC);
    assign running  = (s_r.st == scp_pkg::ST_RUN) || (s_r.st == scp_pkg::ST_WAKE);
    assign tosc_ok  = s_r.rc_sel && running;

    // start pulses of the two delay counters
    always_comb
    begin
        ck_start = 1'b0;
        ck_load  = scp_pkg::RESET_CK_CYCLES;
        ms_start = 1'b0;
        ms_load  = 14'h0000;
        case (s_r.st)
            scp_pkg::ST_LATCH:
            begin
                ck_start = 1'b1;
                ck_load  = scp_pkg::RESET_CK_CYCLES;
            end
            scp_pkg::ST_CK:
            begin
                ms_start = ck_done;
                case (s_r.fuse.startup_time_fuses)
                    scp_pkg::SUT_CK_ONLY: ms_load = 14'h0000;
                    scp_pkg::SUT_SHORT:   ms_load = SHORT_LOAD;
                    scp_pkg::SUT_LONG:    ms_load = LONG_LOAD;
                    // the reserved code gets the safest, longest delay
                    default:              ms_load = LONG_LOAD;
                endcase
            end
            scp_pkg::ST_RUN:
            begin
                ck_start = WAKE_REQ;
                ck_load  = scp_pkg::WAKE_CK_CYCLES;
            end
            default:
            begin
                ck_start = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.rdata     = 8'h00;
        s_nxt.wake_done = 1'b0;
        s_nxt.xtal_prev = MAIN_CLOCK_INPUT_PIN;
        s_nxt.tosc_prev = TIMER_OSC_PIN_ONE;
        s_nxt.asy_tick  = 1'b0;

        // sequencing of reset release and wake-up
        case (s_r.st)
            scp_pkg::ST_LATCH:
            begin
                // static settings are caught once, right after reset release
                s_nxt.fuse    = FUSE;
                s_nxt.ext_sel = (FUSE.source_select_fuses == scp_pkg::SRC_EXT);
                // unsupported codes fall back to the internal RC
                s_nxt.rc_sel  = (FUSE.source_select_fuses != scp_pkg::SRC_EXT);
                s_nxt.trim    = CAL_BYTE;
                if (FUSE.divide_by_eight_fuse)
                    s_nxt.div_sel = scp_pkg::DIV_CODE_DIV8;
                else
                    s_nxt.div_sel = scp_pkg::DIV_CODE_RESET;
                s_nxt.st = scp_pkg::ST_CK;
            end
            scp_pkg::ST_CK:
            begin
                if (ck_done)
                    s_nxt.st = scp_pkg::ST_MS;
            end
            scp_pkg::ST_MS:
            begin
                // the time-out counts watchdog oscillator ticks only
                if (ms_done)
                    s_nxt.st = scp_pkg::ST_RUN;
            end
            scp_pkg::ST_RUN:
            begin
                if (WAKE_REQ)
                    s_nxt.st = scp_pkg::ST_WAKE;
            end
            scp_pkg::ST_WAKE:
            begin
                if (ck_done)
                begin
                    s_nxt.st        = scp_pkg::ST_RUN;
                    s_nxt.wake_done = 1'b1;
                end
            end
            default:
            begin
                s_nxt.st = scp_pkg::ST_LATCH;
            end
        endcase

        // unlock window runs out after four cycles
        if (s_r.ce)
        begin
            if (s_r.ce_cnt == 3'h1)
            begin
                s_nxt.ce     = 1'b0;
                s_nxt.ce_cnt = 3'h0;
            end
            else
            begin
                s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
            end
        end

        // register writes, only once the settings have been caught
        if (s_r.st != scp_pkg::ST_LATCH)
        begin
            if (wr_trim)
                s_nxt.trim = WDATA;
            if (wr_async)
                s_nxt.ext_tclk = WDATA[scp_pkg::ASYNC_TIMER_EXTERNAL_CLOCK_SELECT_BIT];
            if (wr_div)
            begin
                if (!s_r.ce && WDATA == scp_pkg::DIVCTL_UNLOCK)
                begin
                    s_nxt.ce     = 1'b1;
                    s_nxt.ce_cnt = scp_pkg::CE_WINDOW;
                end
                else if (s_r.ce && !WDATA[scp_pkg::DIVCTL_CE_BIT])
                begin
                    // a use of the window ends it at once
                    s_nxt.div_sel = WDATA[3:0];
                    s_nxt.ce      = 1'b0;
                    s_nxt.ce_cnt  = 3'h0;
                end
                // a repeated unlock inside the window changes nothing
            end
        end

        // async timer clock bypasses the prescaler
        if (tosc_ok && TIMER_OSC_PIN_ONE && !s_r.tosc_prev)
            s_nxt.asy_tick = 1'b1;

        // read data stand for one cycle only
        if (RD)
        begin
            case (ADDR)
                scp_pkg::ADDR_TRIM:
                    s_nxt.rdata = s_r.trim;
                scp_pkg::ADDR_DIVCTL:
                    s_nxt.rdata = {s_r.ce, 3'h0, s_r.div_sel};
                scp_pkg::ADDR_ASYNC:
                    s_nxt.rdata = 8'(s_r.ext_tclk) << scp_pkg::ASYNC_TIMER_EXTERNAL_CLOCK_SELECT_BIT;
                scp_pkg::ADDR_STATUS:
                begin
                    s_nxt.rdata[scp_pkg::STAT_RC_BIT]   = s_r.rc_sel;
                    s_nxt.rdata[scp_pkg::STAT_EXT_BIT]  = s_r.ext_sel;
                    s_nxt.rdata[scp_pkg::STAT_RUN_BIT]  = running;
                    s_nxt.rdata[scp_pkg::STAT_TOSC_BIT] = tosc_ok;
                end
                default:
                    s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            s_r          <= '0;
            s_r.st       <= scp_pkg::ST_LATCH;
            s_r.rc_sel   <= 1'b1;
            s_r.trim     <= scp_pkg::TRIM_RESET;
            s_r.div_sel  <= scp_pkg::DIV_CODE_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // source-clock counted delays: 14 CK at reset, 6 CK at wake-up
    scp_delay u_ck_delay (
        .clk   (CLOCK),
        .rstn  (RSTN),
        .start (ck_start),
        .load  (ck_load),
        .tick  (src_tick),
        .busy  (),
        .done  (ck_done)
    );

    // reset time-out on the watchdog oscillator
    scp_delay u_ms_delay (
        .clk   (CLOCK),
        .rstn  (RSTN),
        .start (ms_start),
        .load  (ms_load),
        .tick  (WDT_OSC_TICK),
        .busy  (),
        .done  (ms_done)
    );

    // prescaler keeps running through the reset delay so the pin clock is seen
    scp_divider u_divider (
        .clk      (CLOCK),
        .rstn     (RSTN),
        .tick_in  (src_tick),
        .code     (s_r.div_sel),
        .tick_out (div_tick),
        .level    (div_level)
    );

    assign RDATA                 = s_r.rdata;
    assign WAKE_DONE             = s_r.wake_done;
    assign CORE_RESET_N          = running;
    // the system tick stops while held in reset and during the wake delay; the async tick stops in reset and runs only with the internal RC
    assign SYS_TICK              = div_tick && (s_r.st == scp_pkg::ST_RUN);
    assign ASY_TICK              = s_r.asy_tick;
    assign CLOCK_OUTPUT_PIN_O    = s_r.fuse.clock_output_fuse && div_level;
    assign CLOCK_OUTPUT_PIN_OE_N = !s_r.fuse.clock_output_fuse;
    assign RC_OSCILLATOR_TRIM    = s_r.trim;
    assign TOSC_ENABLE           = tosc_ok;
    assign TOSC_EXT_CLOCK        = tosc_ok && s_r.ext_tclk;

endmodule

// ==== dv/scp_partner.sv ====
// free running external clock, timer pin clock and watchdog oscillator ticks
module scp_partner #(
    parameter int MAIN_HALF = 10,
    parameter int TOSC_HALF = 25,
    parameter int WDT_DIV   = 16
) (
    // bench clock
    input  wire logic clk,
    // far side pins
    output logic      main_pin,
    output logic      tosc_pin,
    output logic      wdt_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    int mc = 0;
    int tc = 0;
    int wc = 0;
    initial
    begin
        main_pin = 1'b0;
        tosc_pin = 1'b0;
        wdt_tick = 1'b0;
    end
    // one fixed period, so cycle to cycle drift is zero, well under 16 MHz
    always @(posedge clk)
    begin
        mc <= (mc == MAIN_HALF - 1) ? 0 : mc + 1;
        if (mc == MAIN_HALF - 1)
            main_pin <= ~main_pin;
        tc <= (tc == TOSC_HALF - 1) ? 0 : tc + 1;
        if (tc == TOSC_HALF - 1)
            tosc_pin <= ~tosc_pin;
        wc <= (wc == WDT_DIV - 1) ? 0 : wc + 1;
        wdt_tick <= (wc == WDT_DIV - 1);
    end
endmodule

// ==== dv/scp_assertions.sv ====
// concurrent checks on the clock select and prescaler ports
module scp_assertions (
    // clock and reset
    input wire logic               CLOCK,
    input wire logic               RSTN,
    // register port
    input wire logic [3:0]         ADDR,
    input wire logic [7:0]         WDATA,
    input wire logic               WR,
    // configuration and wake
    input wire scp_pkg::scp_fuse_t FUSE,
    input wire logic               WAKE_REQ,
    // observed outputs
    input wire logic               WAKE_DONE,
    input wire logic               CORE_RESET_N,
    input wire logic               SYS_TICK,
    input wire logic               ASY_TICK,
    input wire logic               CLOCK_OUTPUT_PIN_O,
    input wire logic               CLOCK_OUTPUT_PIN_OE_N,
    input wire logic [7:0]         RC_OSCILLATOR_TRIM,
    input wire logic               TOSC_ENABLE,
    input wire logic               TOSC_EXT_CLOCK
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    // cycles spent in the reset delay, saturating so it never wraps
    logic [15:0] rcnt_r;
    always_ff @(posedge CLOCK or negedge RSTN)
        if (!RSTN)
            rcnt_r <= 16'h0000;
        else if (!CORE_RESET_N && rcnt_r != 16'hFFFF)
            rcnt_r <= rcnt_r + 16'h0001;
    a_rst_min: assert property ($rose(CORE_RESET_N) |-> rcnt_r >= 16'h000E)
        else $error("reset delay shorter than 14 cycles");
    a_trim_write: assert property (CORE_RESET_N && WR && ADDR == scp_pkg::ADDR_TRIM
        |=> RC_OSCILLATOR_TRIM == $past(WDATA)) else $error("trim write lost");
    a_trim_hold: assert property (CORE_RESET_N && $past(CORE_RESET_N) && !$past(WR)
        |-> $stable(RC_OSCILLATOR_TRIM)) else $error("trim moved without write");
    a_clock_output_pin_off: assert property (!FUSE.clock_output_fuse |-> !CLOCK_OUTPUT_PIN_O)
        else $error("clock output active with fuse clear");
    a_clock_output_pin_drive: assert property (CORE_RESET_N
        |-> CLOCK_OUTPUT_PIN_OE_N == !FUSE.clock_output_fuse) else $error("clock pin enable");
    a_tosc_rc: assert property (TOSC_ENABLE
        |-> FUSE.source_select_fuses != scp_pkg::SRC_EXT) else $error("timer osc on ext");
    a_tosc_ext: assert property (TOSC_EXT_CLOCK |-> TOSC_ENABLE)
        else $error("timer ext clock without timer osc");
    a_asy_gate: assert property (ASY_TICK |-> TOSC_ENABLE || $past(TOSC_ENABLE))
        else $error("async tick without timer osc");
    a_sys_run: assert property (SYS_TICK |-> CORE_RESET_N)
        else $error("system tick during reset delay");
    a_wake_rc: assert property (WAKE_REQ && CORE_RESET_N
        && FUSE.source_select_fuses == scp_pkg::SRC_RC
        |=> !WAKE_DONE [*4] ##[1:4] WAKE_DONE) else $error("wake delay not 6 cycles");
endmodule

// ==== dv/tb.sv ====
// self-checking bench of the clock select and prescaler
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clock = 1'b0;
    logic               rstn = 1'b0;
    logic [3:0]         addr = 4'h0;
    logic [7:0]         wdata = 8'h00;
    logic               wr = 1'b0;
    logic               rd = 1'b0;
    logic               wake_req = 1'b0;
    logic [7:0]         cal = 8'h00;
    scp_pkg::scp_fuse_t fuse = '0;
    logic [7:0]         rdata, trim, d;
    logic               main_pin, tosc_pin, wdt_tick, wake_done, core_rst_n, sys_tick;
    logic               asy_tick, clock_output_pin, clock_output_pin_oe_n, tosc_en, tosc_ext;
    logic [3:0]         cur;
    int                 errors = 0;
    int                 n_compared = 0;
    int                 cyc = 0;
    int                 sp, n, nr, mx;
    bit                 rc;
    always #2 clock = ~clock;
    scp_partner u_far (.clk(clock), .main_pin(main_pin), .tosc_pin(tosc_pin),
        .wdt_tick(wdt_tick));
    // short ms delays keep each reset under a few hundred cycles
    scp_top #(.RST_SHORT_TICKS(3), .RST_LONG_TICKS(5)) DUT (.CLOCK(clock), .RSTN(rstn),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .FUSE(fuse),
        .CAL_BYTE(cal), .MAIN_CLOCK_INPUT_PIN(main_pin), .TIMER_OSC_PIN_ONE(tosc_pin),
        .WDT_OSC_TICK(wdt_tick), .WAKE_REQ(wake_req), .WAKE_DONE(wake_done),
        .CORE_RESET_N(core_rst_n), .SYS_TICK(sys_tick), .ASY_TICK(asy_tick),
        .CLOCK_OUTPUT_PIN_O(clock_output_pin), .CLOCK_OUTPUT_PIN_OE_N(clock_output_pin_oe_n),
        .RC_OSCILLATOR_TRIM(trim), .TOSC_ENABLE(tosc_en), .TOSC_EXT_CLOCK(tosc_ext));
    task conclude();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // every bus signal changes once per edge, so strobes may run back to back
    task drive(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= v;
    endtask
    task rdx(input logic [3:0] a, output logic [7:0] v);
        drive(1'b0, 1'b1, a, 8'h00);
        drive(1'b0, 1'b0, 4'h0, 8'h00);
        #1 v = rdata;
    endtask
    task expect_rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rdx(a, v);
        check(v, exp);
    endtask
    task gap(output int g);
        g = 0;
        do
        begin
            @(negedge clock);
            g++;
        end
        while (sys_tick !== 1'b1 && g < 9000);
    endtask
    // unlock, optional second unlock, idle cycles, then a divider write
    task try(input logic [7:0] pre, input bit twice, input int g, input bit ok);
        logic [3:0] c;
        c = 4'((cur + 1 + $urandom_range(6, 0)) % 9);
        drive(1'b1, 1'b0, scp_pkg::ADDR_DIVCTL, pre); // sequence kept whole
        if (twice)
            drive(1'b1, 1'b0, scp_pkg::ADDR_DIVCTL, pre);
        repeat (g) drive(1'b0, 1'b0, 4'h0, 8'h00);
        drive(1'b1, 1'b0, scp_pkg::ADDR_DIVCTL, {4'h0, c});
        if (ok)
            cur = c;
        expect_rd(scp_pkg::ADDR_DIVCTL, {4'h0, cur});
    endtask
    // one divided period in bench cycles: the factor is two to the code
    function automatic int period(input int s, input logic [3:0] c);
        return s << c;
    endfunction
    task meas(input logic [3:0] c);
        int g1, g2, g3, g4, fo, fn;
        logic [7:0] v;
        // let a stale long period end so the divider runs on the setting read back
        gap(g1);
        fo = period(sp, cur);
        fn = period(sp, c);
        drive(1'b1, 1'b0, scp_pkg::ADDR_DIVCTL, 8'h80);
        rdx(scp_pkg::ADDR_DIVCTL, v);
        check(v, {4'h8, cur});
        drive(1'b1, 1'b0, scp_pkg::ADDR_DIVCTL, {4'h0, c});
        drive(1'b0, 1'b0, 4'h0, 8'h00);
        gap(g1);
        gap(g2);
        gap(g3);
        gap(g4);
        check(g2 >= (fo < fn ? fo : fn), 1);
        check(g1 + g2 <= fo + 2 * fn + 2, 1);
        check(g4, fn);
        cur = c;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'h8FF7));
        for (int i = 0; i < 6; i++)
        begin
            rc = (i < 3);
            sp = rc ? 1 : 20;
            @(posedge clock);
            rstn <= 1'b0;
            cal <= 8'($urandom);
            fuse <= '{rc ? scp_pkg::SRC_RC : scp_pkg::SRC_EXT, 2'((i == 5) ? 3 : i % 3),
                i[0], i[0] ^ i[1]}; // last pass takes the reserved start-up code
            repeat (4) @(posedge clock);
            rstn <= 1'b1;
            n = 0;
            nr = 0;
            do
            begin
                @(negedge clock);
                n++;
                nr += (clock_output_pin === 1'b1);
            end
            while (core_rst_n !== 1'b1 && n < 3000);
            mx = 14 * sp + ((i % 3 == 0) ? 0 : (i % 3 == 1) ? 3 : 5) * 16 + 16 + sp + 8;
            // the first source edge may come right after release, so 14 edges span 13 periods
            check(n > 13 * sp && n <= mx, 1);
            check(nr != 0, fuse.clock_output_fuse);
            check(clock_output_pin_oe_n, !fuse.clock_output_fuse);
            cur = fuse.divide_by_eight_fuse ? 4'h3 : 4'h0;
            expect_rd(scp_pkg::ADDR_DIVCTL, {4'h0, cur});
            expect_rd(scp_pkg::ADDR_TRIM, cal);
            expect_rd(scp_pkg::ADDR_STATUS, rc ? 8'h0D : 8'h06);
            expect_rd(4'h9, 8'h00);
            d = 8'($urandom) & 8'h40;
            drive(1'b1, 1'b0, scp_pkg::ADDR_ASYNC, d);
            expect_rd(scp_pkg::ADDR_ASYNC, d);
            check(tosc_ext, d[6] & rc);
            check(tosc_en, rc);
            d = 8'($urandom);
            // no memory writes run here, so any trim value is safe
            drive(1'b1, 1'b0, scp_pkg::ADDR_TRIM, d);
            expect_rd(scp_pkg::ADDR_TRIM, d);
            check(trim, d);
            n = 0;
            repeat (200)
            begin
                @(negedge clock);
                n += (asy_tick === 1'b1);
            end
            check(n != 0, rc);
            @(posedge clock);
            wake_req <= 1'b1;
            @(posedge clock);
            wake_req <= 1'b0;
            n = 0;
            do
            begin
                @(negedge clock);
                n++;
            end
            while (wake_done !== 1'b1 && n < 500);
            check(n >= 5 * sp && n <= 7 * sp + 4, 1);
            try(8'h80, 0, 0, 1);
            try(8'h80, 0, 3, 1);
            try(8'h80, 0, 4, 0);
            try(8'h81, 0, 0, 0);
            try(8'h00, 0, 0, 0);
            try(8'h80, 1, 2, 1);
            try(8'h80, 1, 3, 0);
            if (i == 0)
                for (int c = 0; c < 9; c++)
                    meas(4'(c));
            else
                meas(4'($urandom_range(rc ? 8 : 4, 0)));
        end
        conclude();
    end
endmodule
bind scp_top scp_assertions u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .FUSE(FUSE), .WAKE_REQ(WAKE_REQ), .WAKE_DONE(WAKE_DONE),
    .CORE_RESET_N(CORE_RESET_N), .SYS_TICK(SYS_TICK), .ASY_TICK(ASY_TICK),
    .CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O), .CLOCK_OUTPUT_PIN_OE_N(CLOCK_OUTPUT_PIN_OE_N),
    .RC_OSCILLATOR_TRIM(RC_OSCILLATOR_TRIM), .TOSC_ENABLE(TOSC_ENABLE),
    .TOSC_EXT_CLOCK(TOSC_EXT_CLOCK));
